// ### csp_pkg.sv
/*
 * csp_pkg: constants and carrier types for the two memory-mapped slave
 * ports (control/status and transceiver reconfiguration).
 * Assumes: a single 10 MHz clock feeds both ports.
 */
package csp_pkg;

	// address and data widths
	localparam int STAT_AW = 16;
	localparam int RCFG_AW = 12;
	localparam int DW = 32;

	// implemented register words per port; higher addresses are undefined
	localparam int STAT_WORDS = 16;
	localparam int RCFG_WORDS = 16;
	localparam int IDX_W = 4;

	// read timing, in clk cycles
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] STAT_RD_LAT = 8'h08;
	localparam logic [CNT_W-1:0] STAT_RD_TIMEOUT = 8'h64;

	// reset values
	localparam logic [DW-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

	// control/status port sequencer, one-hot
	typedef enum logic [3:0] {
		CSP_ST_IDLE = 4'b0001,
		CSP_ST_WRITE = 4'b0010,
		CSP_ST_READ = 4'b0100,
		CSP_ST_DONE = 4'b1000
	} csp_stat_state_t;

	// reconfiguration port sequencer, one-hot
	typedef enum logic [1:0] {
		CSP_RC_IDLE = 2'b01,
		CSP_RC_ACK = 2'b10
	} csp_rcfg_state_t;

	typedef struct packed {
		logic [STAT_AW-1:0] addr;
		logic read;
		logic write;
		logic [DW-1:0] writedata;
	} csp_stat_req_t;

	typedef struct packed {
		logic [RCFG_AW-1:0] addr;
		logic read;
		logic write;
		logic [DW-1:0] writedata;
	} csp_rcfg_req_t;

endpackage

// ### csp_slave_ports.sv
/*
 * csp_slave_ports: control/status slave port with variable read latency
 * and read timeout, plus a separate transceiver reconfiguration slave port.
 * Assumes: the master holds each request stable until waitrequest is low,
 * keeps at most one read pending, and drives both ports from clk.
 */
`timescale 1ns/1ps

// Notes on behaviour
// R1: registers reachable by external master, read/write
// R2: master keeps only one read outstanding
// R3: non-pipelined, device stalls, master holds request
// R4: 16-bit address, strobes, 32-bit data both ways
// R5: valid marks the cycle read data ready
// R6: waitrequest high until access can complete
// R7: fixed counter times reads, flags timeout
// R8: status port on status clock, sync reset
// R9: master tolerates long read latency
// R10: separate reconfig port, 12-bit address
// R11: reconfig port has its own sync reset
// R12: master holds request stable while waiting
module csp_slave_ports (
	input wire logic clk,
	input wire logic nrst,
	input wire logic statusReset,
	input wire csp_pkg::csp_stat_req_t statReq,
	output logic [csp_pkg::DW-1:0] statReaddata,
	output logic statReaddataValid,
	output logic statWaitrequest,
	output logic statReadTimeout,
	input wire logic reconfigReset,
	input wire csp_pkg::csp_rcfg_req_t rcfgReq,
	output logic [csp_pkg::DW-1:0] rcfgReaddata,
	output logic rcfgWaitrequest
);

	// limitation: sixteen words per port stand in for the register map;
	// the rest of the address space times out (status) or reads back
	// zero (reconfig), and writes there are dropped

	// all port state lives in one struct, registered in one place
	typedef struct packed {
		csp_pkg::csp_stat_state_t stState;
		logic [csp_pkg::CNT_W-1:0] rdCount;
		logic rdHit;
		logic timedOut;
		logic [csp_pkg::DW-1:0] stData;
		logic [csp_pkg::STAT_WORDS-1:0][csp_pkg::DW-1:0] stMem;
		csp_pkg::csp_rcfg_state_t rcState;
		logic [csp_pkg::DW-1:0] rcData;
		logic [csp_pkg::RCFG_WORDS-1:0][csp_pkg::DW-1:0] rcMem;
	} csp_core_t;

	// registered state and its next value
	csp_core_t core_r;
	csp_core_t core_nxt;

	// address decode results
	logic stDefined;
	logic rcDefined;
	logic [csp_pkg::IDX_W-1:0] stIdx;
	logic [csp_pkg::IDX_W-1:0] rcIdx;

	// address decode: only the low words are backed by storage
	assign stIdx = statReq.addr[csp_pkg::IDX_W-1:0];
	assign rcIdx = rcfgReq.addr[csp_pkg::IDX_W-1:0];
	assign stDefined = (statReq.addr < 16'(csp_pkg::STAT_WORDS)); // R4
	assign rcDefined = (rcfgReq.addr < 12'(csp_pkg::RCFG_WORDS)); // R10

	// read counter end points; compared one below the limit because the
	// move to the completion state lands on the following edge
	logic stRdLast;
	logic stRdExpired;
	assign stRdLast = (core_r.rdCount ==
	    csp_pkg::STAT_RD_LAT - 8'h01); // R5
	assign stRdExpired = (core_r.rdCount ==
	    csp_pkg::STAT_RD_TIMEOUT - 8'h01); // R7

	// completion decode, shared by the handshake outputs
	logic stDone;
	logic stWrAck;
	assign stDone = (core_r.stState == csp_pkg::CSP_ST_DONE);
	assign stWrAck = (core_r.stState == csp_pkg::CSP_ST_WRITE);

	// next-state logic for both ports
	always_comb begin
		core_nxt = core_r;

		// status port sequencer
		case (core_r.stState)
			csp_pkg::CSP_ST_IDLE: begin
				// counter and flag start clean for every read
				core_nxt.rdCount = csp_pkg::CNT_RST;
				core_nxt.timedOut = 1'b0;
				// read wins if both strobes arrive together
				if (statReq.read) begin
					core_nxt.stState = csp_pkg::CSP_ST_READ; // R3
					core_nxt.rdHit = stDefined;
				end else if (statReq.write) begin
					core_nxt.stState = csp_pkg::CSP_ST_WRITE; // R3
				end
			end

			csp_pkg::CSP_ST_WRITE: begin
				// write completes this cycle, waitrequest low
				// undefined words drop the data but still complete
				if (stDefined) begin
					core_nxt.stMem[stIdx] = statReq.writedata; // R1
				end
				core_nxt.stState = csp_pkg::CSP_ST_IDLE;
			end

			csp_pkg::CSP_ST_READ: begin
				// fixed counter times every read
				core_nxt.rdCount = core_r.rdCount + 8'h01; // R7
				// address is held, so the word is refetched each cycle
				core_nxt.stData = core_r.stMem[stIdx];
				if (core_r.rdHit && stRdLast) begin
					core_nxt.stState = csp_pkg::CSP_ST_DONE; // R5
				end else if (stRdExpired) begin
					// undefined address: data never arrives
					core_nxt.stState = csp_pkg::CSP_ST_DONE; // R7
					core_nxt.timedOut = 1'b1; // R7
					core_nxt.stData = csp_pkg::DATA_RST;
				end
			end

			csp_pkg::CSP_ST_DONE: begin
				// one completion cycle, then back to idle
				core_nxt.stState = csp_pkg::CSP_ST_IDLE;
			end

			default: begin
				// illegal code: recover to idle
				core_nxt.stState = csp_pkg::CSP_ST_IDLE;
			end
		endcase

		// sync status reset drops any access in flight
		if (statusReset) begin
			core_nxt.stState = csp_pkg::CSP_ST_IDLE; // R8
			core_nxt.rdCount = csp_pkg::CNT_RST;
			core_nxt.rdHit = 1'b0;
			core_nxt.timedOut = 1'b0;
			core_nxt.stData = csp_pkg::DATA_RST;
		end

		// reconfiguration port: one wait cycle per access
		case (core_r.rcState)
			csp_pkg::CSP_RC_IDLE: begin
				// word fetched at take, shown during the ack cycle
				if (rcfgReq.read || rcfgReq.write) begin
					core_nxt.rcState = csp_pkg::CSP_RC_ACK; // R10
					core_nxt.rcData = rcDefined ? core_r.rcMem[rcIdx] :
					    csp_pkg::DATA_RST;
				end
			end

			csp_pkg::CSP_RC_ACK: begin
				// request still held here, so the write lands now
				if (rcfgReq.write && rcDefined) begin
					core_nxt.rcMem[rcIdx] = rcfgReq.writedata; // R10
				end
				core_nxt.rcState = csp_pkg::CSP_RC_IDLE;
			end

			default: begin
				// illegal code: recover to idle
				core_nxt.rcState = csp_pkg::CSP_RC_IDLE;
			end
		endcase

		// its own reset, independent of the status port
		if (reconfigReset) begin
			core_nxt.rcState = csp_pkg::CSP_RC_IDLE; // R11
			core_nxt.rcData = csp_pkg::DATA_RST;
		end
	end

	// single state register; storage keeps contents over sync resets
	// only the asynchronous reset clears the word storage, so software
	// settings survive a port reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_r <= '{
				stState: csp_pkg::CSP_ST_IDLE,
				rdCount: csp_pkg::CNT_RST,
				rdHit: 1'b0,
				timedOut: 1'b0,
				stData: csp_pkg::DATA_RST,
				stMem: '0,
				rcState: csp_pkg::CSP_RC_IDLE,
				rcData: csp_pkg::DATA_RST,
				rcMem: '0
			};
		end else begin
			core_r <= core_nxt;
		end
	end

	// handshake outputs; data comes straight from flops
	// status walk, counted from the edge that takes a request:
	//   write: one cycle later waitrequest drops and the word lands
	//   read: eight counting cycles, then valid with waitrequest low
	//   undefined read: timeout after the full count, data zero
	// each completion stands one cycle, so a master that keeps its
	// strobe one cycle too long starts a second access
	assign statWaitrequest = !(stWrAck || stDone); // R6
	assign statReaddataValid = stDone && !core_r.timedOut; // R5
	assign statReadTimeout = stDone && core_r.timedOut; // R7
	assign statReaddata = core_r.stData;

	// reconfig port: one wait cycle, then a single ack cycle
	assign rcfgWaitrequest = (core_r.rcState != csp_pkg::CSP_RC_ACK); // R10
	assign rcfgReaddata = core_r.rcData;

endmodule // csp_slave_ports

// ### csp_slave_ports_chk.sv
/* csp_slave_ports_chk: port assertions for csp_slave_ports.
 * Assumes: one clk, nrst async, master holds requests. */
`timescale 1ns/1ps
module csp_slave_ports_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic statusReset,
	input wire csp_pkg::csp_stat_req_t statReq,
	input wire logic statReaddataValid,
	input wire logic statWaitrequest,
	input wire logic statReadTimeout,
	input wire csp_pkg::csp_rcfg_req_t rcfgReq,
	input wire logic rcfgWaitrequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// completion shapes and latencies
	property p_vl; statReaddataValid |-> !statWaitrequest; endproperty
	a_vl: assert property (p_vl) else $error("valid busy");
	property p_to; statReadTimeout |-> !statReaddataValid; endproperty
	a_to: assert property (p_to) else $error("timeout valid");
	property p_wl; !statWaitrequest |=> statWaitrequest; endproperty
	a_wl: assert property (p_wl) else $error("wait low");
	property p_rd; $rose(statReq.read) && statReq.addr < 16
		|-> ##9 statReaddataValid; endproperty
	a_rd: assert property (p_rd) else $error("read lat");
	property p_ud; $rose(statReq.read) && statReq.addr >= 16
		|-> ##101 statReadTimeout; endproperty
	a_ud: assert property (p_ud) else $error("timeout lat");
	property p_wr; $rose(statReq.write) |=> !statWaitrequest; endproperty
	a_wr: assert property (p_wr) else $error("write lat");
	property p_rc; $rose(rcfgReq.read) |=> !rcfgWaitrequest; endproperty
	a_rc: assert property (p_rc) else $error("rcfg lat");
	property p_rs; statusReset |=> statWaitrequest; endproperty
	a_rs: assert property (p_rs) else $error("reset");
	c_vl: cover property (statReaddataValid);
	c_to: cover property (statReadTimeout);
	c_rc: cover property (!rcfgWaitrequest);
endmodule // csp_slave_ports_chk
bind csp_slave_ports csp_slave_ports_chk chk (.clk(clk), .nrst(nrst),
	.statusReset(statusReset), .statReq(statReq),
	.statReaddataValid(statReaddataValid), .statWaitrequest(statWaitrequest),
	.statReadTimeout(statReadTimeout), .rcfgReq(rcfgReq),
	.rcfgWaitrequest(rcfgWaitrequest));

// ### csp_master_model.sv
/* csp_master_model: status-port master holding a command till done.
 * Assumes: the bench pulses go only while the model is idle. */
`timescale 1ns/1ps
module csp_master_model (
	input wire logic clk,
	input wire logic go,
	input wire csp_pkg::csp_stat_req_t cmd,
	input wire logic statWaitrequest,
	output csp_pkg::csp_stat_req_t req
);
	initial req = '0;
	// released lines flip so stale values never look valid
	always @(posedge clk) begin
		if (go && !req.read && !req.write) begin
			req <= cmd;
		end else if (!statWaitrequest) begin
			req <= {~req.addr, 2'b00, ~req.writedata};
		end
	end
endmodule // csp_master_model

// ### csp_slave_ports_tb.sv
/* csp_slave_ports_tb: self-checking bench for both slave ports.
 * Assumes: package, design, model and checker compiled first. */
`timescale 1ns/1ps
module csp_slave_ports_tb;
	logic clk = 0, nrst = 0, statusReset = 0, reconfigReset = 0, go = 0;
	csp_pkg::csp_stat_req_t cmd = '0, statReq;
	csp_pkg::csp_rcfg_req_t rcfgReq = '0;
	logic [31:0] statReaddata, rcfgReaddata, q;
	logic statReaddataValid, statWaitrequest, statReadTimeout;
	logic rcfgWaitrequest, v, t;
	int err_count = 0, checks = 0, n;
	always #50 clk = ~clk;
	csp_master_model mst (.clk(clk), .go(go), .cmd(cmd),
		.statWaitrequest(statWaitrequest), .req(statReq));
	csp_slave_ports DUT (.clk(clk), .nrst(nrst), .statusReset(statusReset),
		.statReq(statReq), .statReaddata(statReaddata),
		.statReaddataValid(statReaddataValid),
		.statWaitrequest(statWaitrequest), .statReadTimeout(statReadTimeout),
		.reconfigReset(reconfigReset), .rcfgReq(rcfgReq),
		.rcfgReaddata(rcfgReaddata), .rcfgWaitrequest(rcfgWaitrequest));
	task chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// status access via the master model; n counts cycles to completion
	task st(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 cmd = '{a, !w, w, d};
		go = 1;
		@(posedge clk);
		#1 go = 0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (statWaitrequest !== 1'b0 && n < 200);
		q = statReaddata;
		v = statReaddataValid;
		t = statReadTimeout;
	endtask
	// reconfig access driven directly, released with flipped lines
	task rc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 rcfgReq = '{a, !w, w, d};
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rcfgWaitrequest !== 1'b0 && n < 20);
		q = rcfgReaddata;
		@(posedge clk);
		#1 rcfgReq = '{~a, 1'b0, 1'b0, ~d};
	endtask
	task t_run;
		statusReset = 1;
		reconfigReset = 1;
		@(posedge clk);
		#1 statusReset = 0;
		reconfigReset = 0;
		chk("swait", 1'h1, statWaitrequest);
		chk("rwait", 1'h1, rcfgWaitrequest);
		st(1, 16'h0003, 32'hA5A5_0F0F);
		chk("wrlat", 32'h0000_0002, n);
		st(0, 16'h0003, 32'h0000_0000);
		chk("rdlat", csp_pkg::STAT_RD_LAT + 8'h02, n);
		chk("rdata", 32'hA5A5_0F0F, q);
		chk("valid", 1'h1, v);
		st(0, 16'h0010, 32'h0000_0000);
		chk("tolat", csp_pkg::STAT_RD_TIMEOUT + 8'h02, n);
		chk("tout", 1'h1, t);
		chk("toval", 1'h0, v);
		rc(1, 12'h005, 32'h1234_5678);
		chk("rclat", 32'h0000_0002, n);
		rc(0, 12'h005, 32'h0000_0000);
		chk("rcdata", 32'h1234_5678, q);
		rc(0, 12'h010, 32'h0000_0000);
		chk("rcund", 32'h0000_0000, q);
		$display("test run done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 nrst = 1;
		t_run;
		final_report;
	end
	// watchdog, far beyond the expected run of about 130 cycles
	initial begin
		#200_000;
		err_count++;
		final_report;
	end
endmodule // csp_slave_ports_tb
